// ---- hw/txlc_atten_rom.sv ----
// fixed attenuation lookup table, quarter dB per entry
`timescale 1ns/1ps
`include "txlc_defs.svh"

module txlc_atten_rom
    import txlc_pkg::*;
(
    input wire logic [8:0] word_i, // attenuation word
    output logic [8:0] atten_qdb_o // attenuation in 0.25 dB steps
);

    logic [8:0] tab [0:`TXLC_TAB_DEPTH-1];
    logic [8:0] idx;

    // constant table, no write path exists
    genvar i;
    generate
        for (i = 0; i < `TXLC_TAB_DEPTH; i++)
        begin : g_tab
            assign tab[i] = 9'(i);
        end
    endgenerate

    // words above the last entry stick at the last entry
    assign idx = (word_i > `TXLC_WORD_MAX) ? `TXLC_WORD_MAX : word_i;
    assign atten_qdb_o = tab[idx];

endmodule

// ---- hw/txlc_defs.svh ----
// register offsets, field positions, reset values and timing counts for tx level control
`ifndef TXLC_DEFS_SVH
`define TXLC_DEFS_SVH

// register port widths
`define TXLC_ADDR_W 10
`define TXLC_DATA_W 8

// attenuation word and table
`define TXLC_WORD_W 9
`define TXLC_TAB_DEPTH 360
`define TXLC_WORD_MAX 9'h167

// register offsets
`define TXLC_REG_LPF_LOW 10'h067
`define TXLC_REG_LPF_HIGH 10'h068
`define TXLC_REG_READ_A 10'h06B
`define TXLC_REG_READ_B 10'h06C
`define TXLC_REG_READ_LSB 10'h06D
`define TXLC_REG_MON_EN 10'h06E
`define TXLC_REG_MON_WIN 10'h06F
`define TXLC_REG_MON1_CFG 10'h070
`define TXLC_REG_MON2_CFG 10'h071
`define TXLC_REG_ATT_A_LO 10'h073
`define TXLC_REG_ATT_A_HI 10'h074
`define TXLC_REG_ATT_B_LO 10'h075
`define TXLC_REG_ATT_B_HI 10'h076
`define TXLC_REG_THRESH 10'h078

// field positions
`define TXLC_LPF_IDX_MSB 4
`define TXLC_TRACK_BIT 5
`define TXLC_EN_BIT_HI 7
`define TXLC_EN_BIT_LO 5
`define TXLC_FE_GAIN_MSB 1
`define TXLC_CONT_BIT 2
`define TXLC_DEFER_BIT 5
`define TXLC_SHARE_BIT 6
`define TXLC_WIN_MSB 2

// reset values
`define TXLC_RST_BYTE 8'h00
`define TXLC_RST_WORD 9'h000

// measurement window: 2**exponent samples, exponent up to 7
`define TXLC_ACC_W 16
`define TXLC_CNT_W 8

`endif

// ---- hw/txlc_pkg.sv ----
// types shared by the tx level control block
package txlc_pkg;

    // register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [9:0] addr;
        logic [7:0] wdata;
    } txlc_req_s;

    // per channel monitor controls towards the analog front end
    typedef struct packed {
        logic route_en;
        logic meas_en;
        logic track_en;
        logic tia_high;
        logic [1:0] fe_gain;
        logic [4:0] lpf_idx;
    } txlc_mon_ctl_s;

    // measurement sequencer states
    typedef enum logic [2:0] {
        TXLC_IDLE = 3'b001,
        TXLC_RUN = 3'b010,
        TXLC_DONE = 3'b100
    } txlc_state_e;

endpackage

// ---- hw/txlc_top.sv ----
// tx attenuation control and tx level monitor with its register port
// Behaviour
// - each transmitter has its own 9-bit attenuation word
// - word indexes a fixed 360-entry table at 0.25 dB per step
// - word 0 gives 0 dB, word 359 gives 89.75 dB
// - table contents are constants with no write path
// - host may write any time; default mode applies the word right after
// - deferred mode holds the word until an alert cycle has passed
// - shared select makes both transmitters use the first word; clear by default
// - monitor works only in time-division mode using the idle receiver
// - monitor routed after the low-noise amplifier, level circuit on during burst
// - reading is windowed level in negative full scale, 0.25 dB per step
// - measurement starts when the sequencer enters transmit
// - measure once per transmit entry or repeat until transmit ends
// - front-end gain from bits 1:0 of each channel's config register
// - two 5-bit fields hold low and high lowpass gain indices, 0 to 24 dB
// - word at or below 8-bit threshold picks low index, else high index
// - transimpedance gain switches automatically with no host setting
// - readings stored read-only and corrected for monitor gain changes
// - offset tracking bit enables dc offset tracking in monitor path
`timescale 1ns/1ps
`include "txlc_defs.svh"

module txlc_top
    import txlc_pkg::*;
(
    input wire logic clk_i, // 125 MHz system clock
    input wire logic nrst_i, // asynchronous reset, active low
    input wire txlc_req_s req_i, // register port request
    output logic [7:0] rd_data_o, // read data, one cycle after rd
    output logic rd_valid_o, // read data valid pulse
    input wire logic tdd_mode_i, // device is in time-division duplex
    input wire logic seq_tx_i, // enable sequencer is in transmit
    input wire logic seq_alert_i, // enable sequencer is in alert
    input wire logic samp_valid_i, // level samples valid
    input wire logic [17:0] samp_level_i, // raw levels, chan b high, chan a low
    output logic [17:0] atten_qdb_o, // applied attenuation, chan b high
    output txlc_mon_ctl_s [1:0] mon_ctl_o, // monitor front end controls
    output logic meas_busy_o // measurement window running
);

    // writable registers
    logic [7:0] lpf_low_q, lpf_high_q, mon_en_q, win_q, thresh_q;
    logic [7:0] cfg_q [0:1];
    logic [8:0] word_q [0:1];
    logic defer_q, share_q;
    // applied words and pending flags
    logic [8:0] applied_q [0:1];
    logic [1:0] pend_q;
    logic [1:0] word_wr;
    logic alert_q, tx_q, alert_done, tx_entry;
    // readings
    logic [8:0] read_q [0:1];
    logic [7:0] rd_data_q;
    logic rd_valid_q;
    // measurement
    txlc_state_e state_q;
    logic [`TXLC_ACC_W-1:0] acc_q [0:1];
    logic [`TXLC_CNT_W-1:0] cnt_q;
    logic [`TXLC_CNT_W-1:0] win_len;
    logic mon_on, win_end;
    logic [8:0] eff_word [0:1];
    logic [1:0] use_high;

    // register writes for configuration
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            lpf_low_q <= `TXLC_RST_BYTE;
            lpf_high_q <= `TXLC_RST_BYTE;
            mon_en_q <= `TXLC_RST_BYTE;
            win_q <= `TXLC_RST_BYTE;
            thresh_q <= `TXLC_RST_BYTE;
            cfg_q[0] <= `TXLC_RST_BYTE;
            cfg_q[1] <= `TXLC_RST_BYTE;
        end
        else if (req_i.wr)
        begin
            case (req_i.addr)
                `TXLC_REG_LPF_LOW: lpf_low_q <= req_i.wdata;
                `TXLC_REG_LPF_HIGH: lpf_high_q <= req_i.wdata;
                `TXLC_REG_MON_EN: mon_en_q <= req_i.wdata;
                `TXLC_REG_MON_WIN: win_q <= req_i.wdata;
                `TXLC_REG_THRESH: thresh_q <= req_i.wdata;
                `TXLC_REG_MON1_CFG: cfg_q[0] <= req_i.wdata;
                `TXLC_REG_MON2_CFG: cfg_q[1] <= req_i.wdata;
                default: ;
            endcase
        end
    end

    // attenuation word registers, one per transmitter
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            word_q[0] <= `TXLC_RST_WORD;
            word_q[1] <= `TXLC_RST_WORD;
            defer_q <= 1'b0;
            share_q <= 1'b0;
        end
        else if (req_i.wr)
        begin
            case (req_i.addr)
                `TXLC_REG_ATT_A_LO: word_q[0][7:0] <= req_i.wdata;
                `TXLC_REG_ATT_A_HI:
                begin
                    word_q[0][8] <= req_i.wdata[0];
                    defer_q <= req_i.wdata[`TXLC_DEFER_BIT];
                    share_q <= req_i.wdata[`TXLC_SHARE_BIT];
                end
                `TXLC_REG_ATT_B_LO: word_q[1][7:0] <= req_i.wdata;
                `TXLC_REG_ATT_B_HI: word_q[1][8] <= req_i.wdata[0];
                default: ;
            endcase
        end
    end

    // which word registers took a write this cycle
    assign word_wr[0] = req_i.wr &&
        (req_i.addr == `TXLC_REG_ATT_A_LO || req_i.addr == `TXLC_REG_ATT_A_HI);
    assign word_wr[1] = req_i.wr &&
        (req_i.addr == `TXLC_REG_ATT_B_LO || req_i.addr == `TXLC_REG_ATT_B_HI);

    // sequencer edge tracking, inputs come from same-clock logic
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            alert_q <= 1'b0;
            tx_q <= 1'b0;
        end
        else
        begin
            alert_q <= seq_alert_i;
            tx_q <= seq_tx_i;
        end
    end

    assign alert_done = alert_q && !seq_alert_i; // alert cycle just finished
    assign tx_entry = seq_tx_i && !tx_q;

    // applied words: immediate, or held until an alert cycle has passed
    genvar c;
    generate
        for (c = 0; c < 2; c++)
        begin : g_apply
            always_ff @(posedge clk_i or negedge nrst_i)
            begin
                if (!nrst_i)
                begin
                    applied_q[c] <= `TXLC_RST_WORD;
                    pend_q[c] <= 1'b0;
                end
                else if (!defer_q)
                begin
                    applied_q[c] <= word_q[c];
                    pend_q[c] <= 1'b0;
                end
                else
                begin
                    if (alert_done && pend_q[c])
                        applied_q[c] <= word_q[c];
                    // a write in the apply cycle stays pending
                    if (word_wr[c])
                        pend_q[c] <= 1'b1;
                    else if (alert_done)
                        pend_q[c] <= 1'b0;
                end
            end

            // shared select routes the first word to both paths
            assign eff_word[c] = share_q ? applied_q[0] : applied_q[c];

            txlc_atten_rom u_rom (
                .word_i(eff_word[c]),
                .atten_qdb_o(atten_qdb_o[c*9 +: 9])
            );

            // low index at or below threshold, high index above
            assign use_high[c] = eff_word[c] > {1'b0, thresh_q};
        end
    endgenerate

    // monitor is usable only in tdd with both enable bits set
    assign mon_on = tdd_mode_i && mon_en_q[`TXLC_EN_BIT_HI] &&
        mon_en_q[`TXLC_EN_BIT_LO];
    assign win_len = `TXLC_CNT_W'(1) << win_q[`TXLC_WIN_MSB:0];
    assign win_end = samp_valid_i && (cnt_q == win_len - `TXLC_CNT_W'(1));
    assign meas_busy_o = (state_q == TXLC_RUN);

    // measurement sequencer
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_q <= TXLC_IDLE;
            cnt_q <= '0;
        end
        else
        begin
            case (state_q)
                TXLC_IDLE:
                begin
                    cnt_q <= '0;
                    if (tx_entry && mon_on)
                        state_q <= TXLC_RUN;
                end
                TXLC_RUN:
                begin
                    if (!seq_tx_i || !mon_on)
                    begin
                        state_q <= TXLC_IDLE;
                        cnt_q <= '0;
                    end
                    else if (win_end)
                    begin
                        cnt_q <= '0;
                        if (!cfg_q[0][`TXLC_CONT_BIT])
                            state_q <= TXLC_DONE;
                    end
                    else if (samp_valid_i)
                        cnt_q <= cnt_q + `TXLC_CNT_W'(1);
                end
                TXLC_DONE:
                begin
                    cnt_q <= '0;
                    if (!seq_tx_i)
                        state_q <= TXLC_IDLE;
                end
                default:
                begin
                    state_q <= TXLC_IDLE;
                    cnt_q <= '0;
                end
            endcase
        end
    end

    // per channel accumulation, gain-corrected reading and front end controls
    generate
        for (c = 0; c < 2; c++)
        begin : g_meas
            logic [4:0] lpf_idx;
            logic [`TXLC_ACC_W-1:0] acc_next;
            logic [`TXLC_ACC_W-1:0] avg;
            logic [10:0] corrected;

            assign lpf_idx = use_high[c] ? lpf_high_q[`TXLC_LPF_IDX_MSB:0] :
                lpf_low_q[`TXLC_LPF_IDX_MSB:0];
            assign acc_next = acc_q[c] + `TXLC_ACC_W'(samp_level_i[c*9 +: 9]);
            assign avg = acc_next >> win_q[`TXLC_WIN_MSB:0];
            // undo the lowpass gain so a threshold crossing leaves no step
            assign corrected = 11'(avg[8:0]) + {4'h0, lpf_idx, 2'b00};

            always_ff @(posedge clk_i or negedge nrst_i)
            begin
                if (!nrst_i)
                begin
                    acc_q[c] <= '0;
                    read_q[c] <= `TXLC_RST_WORD;
                end
                else if (state_q != TXLC_RUN)
                    acc_q[c] <= '0;
                else if (win_end)
                begin
                    acc_q[c] <= '0;
                    read_q[c] <= (corrected > 11'h1FF) ? 9'h1FF : corrected[8:0];
                end
                else if (samp_valid_i)
                    acc_q[c] <= acc_next;
            end

            // front end controls, registered
            always_ff @(posedge clk_i or negedge nrst_i)
            begin
                if (!nrst_i)
                    mon_ctl_o[c] <= '0;
                else
                begin
                    mon_ctl_o[c].route_en <= mon_on && seq_tx_i;
                    mon_ctl_o[c].meas_en <= mon_on && seq_tx_i;
                    mon_ctl_o[c].track_en <= lpf_low_q[`TXLC_TRACK_BIT];
                    mon_ctl_o[c].tia_high <= use_high[c];
                    mon_ctl_o[c].fe_gain <= cfg_q[c][`TXLC_FE_GAIN_MSB:0];
                    mon_ctl_o[c].lpf_idx <= lpf_idx;
                end
            end
        end
    endgenerate

    // register reads, one cycle latency, unmapped offsets read zero
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rd_data_q <= `TXLC_RST_BYTE;
            rd_valid_q <= 1'b0;
        end
        else
        begin
            rd_valid_q <= req_i.rd;
            if (req_i.rd)
            begin
                case (req_i.addr)
                    `TXLC_REG_LPF_LOW: rd_data_q <= lpf_low_q;
                    `TXLC_REG_LPF_HIGH: rd_data_q <= lpf_high_q;
                    `TXLC_REG_READ_A: rd_data_q <= read_q[0][8:1];
                    `TXLC_REG_READ_B: rd_data_q <= read_q[1][8:1];
                    `TXLC_REG_READ_LSB: rd_data_q <= {6'h00, read_q[1][0], read_q[0][0]};
                    `TXLC_REG_MON_EN: rd_data_q <= mon_en_q;
                    `TXLC_REG_MON_WIN: rd_data_q <= win_q;
                    `TXLC_REG_MON1_CFG: rd_data_q <= cfg_q[0];
                    `TXLC_REG_MON2_CFG: rd_data_q <= cfg_q[1];
                    `TXLC_REG_ATT_A_LO: rd_data_q <= word_q[0][7:0];
                    `TXLC_REG_ATT_A_HI: rd_data_q <= {1'b0, share_q, defer_q, 4'h0, word_q[0][8]};
                    `TXLC_REG_ATT_B_LO: rd_data_q <= word_q[1][7:0];
                    `TXLC_REG_ATT_B_HI: rd_data_q <= {7'h00, word_q[1][8]};
                    `TXLC_REG_THRESH: rd_data_q <= thresh_q;
                    default: rd_data_q <= `TXLC_RST_BYTE;
                endcase
            end
        end
    end

    assign rd_data_o = rd_data_q;
    assign rd_valid_o = rd_valid_q;

endmodule

// ---- verif/test_txlc_top.sv ----
// self-checking bench for the tx level control block
`timescale 1ns/1ps
module test_txlc_top
    import txlc_pkg::*;
;
    logic clk_i;
    logic nrst_i = 1'b0;
    txlc_req_s req_i = '0;
    logic tdd_mode_i = 1'b0;
    logic seq_tx_i = 1'b0;
    logic seq_alert_i = 1'b0;
    logic [7:0] rd_data_o;
    logic rd_valid_o;
    logic samp_valid_i;
    logic [17:0] samp_level_i;
    logic [17:0] atten_qdb_o;
    txlc_mon_ctl_s [1:0] mon_ctl_o;
    logic meas_busy_o;
    int error_cnt = 0;
    int n_tests = 0;
    logic [9:0] regs [14] = '{10'h067, 10'h068, 10'h06B, 10'h06C, 10'h06D, 10'h06E, 10'h06F,
        10'h070, 10'h071, 10'h073, 10'h074, 10'h075, 10'h076, 10'h078};
    logic [7:0] thr [3] = '{8'h40, 8'h40, 8'hFF};
    logic [8:0] wd [3] = '{9'h040, 9'h041, 9'h100};
    logic hi [3] = '{1'b0, 1'b1, 1'b1};

    txlc_top txlc_top_i (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .req_i(req_i),
        .rd_data_o(rd_data_o),
        .rd_valid_o(rd_valid_o),
        .tdd_mode_i(tdd_mode_i),
        .seq_tx_i(seq_tx_i),
        .seq_alert_i(seq_alert_i),
        .samp_valid_i(samp_valid_i),
        .samp_level_i(samp_level_i),
        .atten_qdb_o(atten_qdb_o),
        .mon_ctl_o(mon_ctl_o),
        .meas_busy_o(meas_busy_o)
    );

    txlc_level_src txlc_level_src_i (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .active_i(mon_ctl_o[0].route_en),
        .lvl_a_i(9'h041),
        .lvl_b_i(9'h080),
        .samp_valid_o(samp_valid_i),
        .samp_level_o(samp_level_i)
    );

    // clock
    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
        begin
            $display("verification passed");
        end
        else
        begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [17:0] seen, input logic [17:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // one register write, strobe held for a single edge
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk_i);
        req_i <= '{1'b1, 1'b0, a, d};
        @(posedge clk_i);
        req_i <= '0;
    endtask

    // one register read, answer looked at in its valid cycle
    task automatic rd(input logic [9:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        req_i <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_i);
        req_i <= '0;
        #1;
        chk("rd_valid", rd_valid_o, 18'h1);
        chk("rd_data", rd_data_o, exp);
    endtask

    task automatic ctl(input logic t, input logic x);
        @(posedge clk_i);
        tdd_mode_i <= t;
        seq_tx_i <= x;
    endtask

    task automatic wait_busy(input logic v);
        int k;
        k = 0;
        while (meas_busy_o !== v && k < 200)
        begin
            tick(1);
            k++;
        end
        chk("meas_busy", meas_busy_o, v);
    endtask

    // hang guard
    initial
    begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        complete_run();
    end

    initial
    begin
        repeat (16) @(posedge clk_i);
        nrst_i <= 1'b1;
        // reset values, unmapped and read-only places
        foreach (regs[i]) rd(regs[i], 8'h00);
        rd(10'h060, 8'h00);
        wr(10'h06B, 8'hFF);
        rd(10'h06B, 8'h00);
        // end points of the table and the clamp
        wr(10'h073, 8'h67);
        wr(10'h074, 8'h01);
        tick(1);
        chk("atten_max", atten_qdb_o, 18'h167);
        wr(10'h073, 8'hFF);
        tick(1);
        chk("atten_clamp", atten_qdb_o, 18'h167);
        wr(10'h074, 8'h00);
        wr(10'h073, 8'h10);
        wr(10'h075, 8'h2A);
        tick(1);
        chk("atten_pair", atten_qdb_o, {9'h02A, 9'h010});
        rd(10'h073, 8'h10);
        // shared word select
        wr(10'h074, 8'h40);
        tick(1);
        chk("atten_shared", atten_qdb_o, {9'h010, 9'h010});
        wr(10'h074, 8'h00);
        tick(1);
        chk("atten_own", atten_qdb_o, {9'h02A, 9'h010});
        // deferred update waits for the alert cycle, latest write wins
        wr(10'h074, 8'h20);
        wr(10'h073, 8'h30);
        wr(10'h073, 8'h50);
        tick(3);
        chk("atten_held", atten_qdb_o[8:0], 18'h010);
        @(posedge clk_i);
        seq_alert_i <= 1'b1;
        @(posedge clk_i);
        seq_alert_i <= 1'b0;
        tick(1);
        chk("atten_alert", atten_qdb_o[8:0], 18'h050);
        wr(10'h074, 8'h00);
        wr(10'h073, 8'h10);
        // gain index against threshold, boundary cases
        wr(10'h067, 8'h23);
        wr(10'h068, 8'h0A);
        wr(10'h070, 8'h02);
        wr(10'h071, 8'h01);
        for (int i = 0; i < 3; i++)
        begin
            wr(10'h078, thr[i]);
            wr(10'h073, wd[i][7:0]);
            wr(10'h074, {7'h00, wd[i][8]});
            tick(2);
            chk("tia_high", mon_ctl_o[0].tia_high, hi[i]);
            chk("lpf_idx", mon_ctl_o[0].lpf_idx, hi[i] ? 18'hA : 18'h3);
        end
        chk("fe_gain", {mon_ctl_o[1].fe_gain, mon_ctl_o[0].fe_gain}, 18'h6);
        chk("track", mon_ctl_o[0].track_en, 18'h1);
        chk("lpf_b", mon_ctl_o[1].lpf_idx, 18'h3);
        wr(10'h078, 8'h40);
        wr(10'h073, 8'h10);
        wr(10'h074, 8'h00);
        // one-shot window of two samples
        wr(10'h06E, 8'hA0);
        wr(10'h06F, 8'h01);
        ctl(1'b1, 1'b0);
        ctl(1'b1, 1'b1);
        wait_busy(1'b1);
        chk("route", {mon_ctl_o[1].route_en, mon_ctl_o[0].route_en}, 18'h3);
        chk("meas_en", {mon_ctl_o[1].meas_en, mon_ctl_o[0].meas_en}, 18'h3);
        wait_busy(1'b0);
        rd(10'h06B, 8'h26);
        rd(10'h06C, 8'h46);
        rd(10'h06D, 8'h01);
        ctl(1'b1, 1'b0);
        // continuous windows until transmit ends
        wr(10'h070, 8'h06);
        ctl(1'b1, 1'b1);
        wait_busy(1'b1);
        tick(40);
        chk("busy_cont", meas_busy_o, 18'h1);
        ctl(1'b1, 1'b0);
        tick(2);
        chk("busy_stop", meas_busy_o, 18'h0);
        // no monitoring outside tdd
        ctl(1'b0, 1'b0);
        ctl(1'b0, 1'b1);
        tick(10);
        chk("busy_fdd", meas_busy_o, 18'h0);
        chk("route_fdd", mon_ctl_o[0].route_en, 18'h0);
        ctl(1'b0, 1'b0);
        complete_run();
    end
endmodule

// ---- verif/txlc_level_src.sv ----
// front end stand-in giving level samples while the monitor is routed
`timescale 1ns/1ps
module txlc_level_src (
    input wire logic clk_i, // clock
    input wire logic nrst_i, // reset, active low
    input wire logic active_i, // monitor routed in
    input wire logic [8:0] lvl_a_i, // channel a level
    input wire logic [8:0] lvl_b_i, // channel b level
    output logic samp_valid_o, // sample strobe
    output logic [17:0] samp_level_o // levels, chan b high
);
    logic [1:0] cnt_q;
    // free cycle counter paces the samples
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cnt_q <= 2'h0;
        end
        else
        begin
            cnt_q <= cnt_q + 2'h1;
        end
    end
    // a sample every fourth cycle, only while routed after the amplifier
    assign samp_valid_o = active_i && (cnt_q == 2'h3);
    // off the strobe the lines carry a shifting pattern
    assign samp_level_o = samp_valid_o ? {lvl_b_i, lvl_a_i} : ~{lvl_b_i, lvl_a_i} ^ {16'h0, cnt_q};
endmodule

// ---- verif/txlc_top_properties.sv ----
// port assertions for the tx level control block
`timescale 1ns/1ps
module txlc_props
    import txlc_pkg::*;
(
    input wire logic clk_i, // clock
    input wire logic nrst_i, // reset, active low
    input wire txlc_req_s req_i, // register request
    input wire logic [7:0] rd_data_o, // read data
    input wire logic rd_valid_o, // read valid
    input wire logic tdd_mode_i, // tdd mode
    input wire logic seq_tx_i, // sequencer transmit
    input wire logic seq_alert_i, // sequencer alert
    input wire logic [17:0] atten_qdb_o, // applied attenuation
    input wire txlc_mon_ctl_s [1:0] mon_ctl_o, // monitor controls
    input wire logic meas_busy_o // window running
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // register port answers and holds
    read_answer_a: assert property (req_i.rd |=> rd_valid_o)
        else $error("read got no valid");
    read_hold_a: assert property (!req_i.rd |=> !rd_valid_o && $stable(rd_data_o))
        else $error("read data moved without a read");
    // applied attenuation never leaves the table and moves only for a cause
    atten_clamp_a: assert property (atten_qdb_o[8:0] <= 9'h167 && atten_qdb_o[17:9] <= 9'h167)
        else $error("attenuation beyond last entry");
    atten_cause_a: assert property ($changed(atten_qdb_o) |-> $past(req_i.wr, 2)
        || $past(req_i.wr && req_i.addr == 10'h074) // shared select acts one cycle sooner
        || ($past(seq_alert_i, 2) && !$past(seq_alert_i)))
        else $error("attenuation changed without write or alert");
    // monitor sequencing
    tdd_only_a: assert property (!tdd_mode_i [*3] |-> !mon_ctl_o[0].route_en && !mon_ctl_o[1].route_en)
        else $error("monitor routed outside tdd");
    busy_start_a: assert property ($rose(meas_busy_o) |->
        $past(seq_tx_i) && !$past(seq_tx_i, 2) && $past(tdd_mode_i))
        else $error("window began without transmit entry");
    busy_stop_a: assert property (!seq_tx_i |=> !meas_busy_o)
        else $error("window kept running after transmit");
    route_busy_a: assert property (meas_busy_o |-> mon_ctl_o[0].meas_en && mon_ctl_o[1].route_en)
        else $error("level circuit off during window");
endmodule

bind txlc_top txlc_props txlc_props_i (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .req_i(req_i),
    .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o),
    .tdd_mode_i(tdd_mode_i),
    .seq_tx_i(seq_tx_i),
    .seq_alert_i(seq_alert_i),
    .atten_qdb_o(atten_qdb_o),
    .mon_ctl_o(mon_ctl_o),
    .meas_busy_o(meas_busy_o)
);
